// file: rtl/free_run_timer_input_capture.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module free_run_timer_input_capture
    import frt_cap_pkg::*;
#(
    parameter int NCH = 4
)(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic     [31:0]     prdata,
    output logic                pready,
    output logic                pslverr,
    input  wire logic [NCH-1:0] cap_pin,
    output logic                ovf_irq,
    output logic                ovf_xfer_req,
    output logic     [NCH-1:0]  cap_irq,
    output logic     [NCH-1:0]  cap_xfer_req
);

    // Register map and flag layout serve four channels only
    if (NCH != 4) begin : g_nch_check
        $error("NCH must be 4");
    end

    typedef struct packed {
        logic [3:0]            pre;
        logic [15:0]           cnt;
        logic [1:0]            psc;
        logic                  ovf_ie;
        logic                  ovf_xs;
        logic                  ovf_f;
        logic [2*NCH-1:0]      edge_sel;
        logic [NCH-1:0]        cap_ie;
        logic [NCH-1:0]        cap_xs;
        logic [NCH-1:0]        cap_f;
        logic [NCH-1:0][15:0]  cap;
        logic [31:0]           rdata;
        logic                  ready;
        logic                  err;
        logic                  ovf_irq;
        logic                  ovf_xfer;
        logic [NCH-1:0]        cap_irq;
        logic [NCH-1:0]        cap_xfer;
    } state_t;

    state_t         st_q;
    state_t         st_d;
    logic [NCH-1:0] hit;
    logic           tick;
    logic           wr_en;
    logic           clr_wr;

    ////////////////////////////////////////////////////////////////////////
    // Prescaler tap for each ratio
    function automatic logic tick_f(input logic [3:0] pre, input logic [1:0] sel);
        logic [3:0] m;
        m = DIV_MASK0;
        case (sel)
            2'd0:    m = DIV_MASK0;
            2'd1:    m = DIV_MASK1;
            2'd2:    m = DIV_MASK2;
            2'd3:    m = DIV_MASK3;
            default: m = DIV_MASK0;
        endcase
        return (pre & m) == m;
    endfunction

    // Address decode: mapped or not
    function automatic logic mapped_f(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= OFF_CAP3);
    endfunction

    // Read mux over the register file
    function automatic logic [31:0] rd_f(input state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = WORD_RST;
        case (a)
            OFF_CTRL: begin
                r[CTRL_PSC_LSB +: 2] = s.psc;
                r[CTRL_OVF_IE]       = s.ovf_ie;
                r[CTRL_OVF_XS]       = s.ovf_xs;
            end
            OFF_COUNT: r[15:0] = s.cnt;
            OFF_CAPC: begin
                r[CAPC_EDGE_LSB +: 2*NCH] = s.edge_sel;
                r[CAPC_IE_LSB +: NCH]     = s.cap_ie;
                r[CAPC_XS_LSB +: NCH]     = s.cap_xs;
            end
            OFF_STAT: begin
                r[STAT_CAP_LSB +: NCH] = s.cap_f;
                r[STAT_OVF_BIT]        = s.ovf_f;
            end
            default: begin
                if (a >= OFF_CAP0 && a <= OFF_CAP3) begin
                    r[15:0] = s.cap[a[3:2]];
                end
            end
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // One edge detector per capture pin
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        cap_edge_detect u_det (
            .clk      (clk),
            .rst_n    (rst_n),
            .pin      (cap_pin[i]),
            .edge_sel (st_q.edge_sel[2*i +: 2]),
            .hit      (hit[i])
        );
    end

    // Write lands at the access edge where pready is seen high
    assign wr_en  = psel & penable & st_q.ready & pwrite & mapped_f(paddr);
    assign clr_wr = wr_en && (paddr == OFF_CTRL) && pwdata[CTRL_ZERO_BIT];
    assign tick   = tick_f(st_q.pre, st_q.psc);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_d     = st_q;
        st_d.pre = st_q.pre + 4'd1;

        // Single shared counter; clear beats a tick in the same cycle
        if (clr_wr) begin
            st_d.cnt = CNT_RST;
        end else if (tick) begin
            st_d.cnt = st_q.cnt + 16'd1;
        end

        // Software writes to control registers and write-one-to-clear of the status register
        if (wr_en) begin
            case (paddr)
                OFF_CTRL: begin
                    st_d.psc    = pwdata[CTRL_PSC_LSB +: 2];
                    st_d.ovf_ie = pwdata[CTRL_OVF_IE];
                    st_d.ovf_xs = pwdata[CTRL_OVF_XS];
                end
                OFF_CAPC: begin
                    st_d.edge_sel = pwdata[CAPC_EDGE_LSB +: 2*NCH];
                    st_d.cap_ie   = pwdata[CAPC_IE_LSB +: NCH];
                    st_d.cap_xs   = pwdata[CAPC_XS_LSB +: NCH];
                end
                OFF_STAT: begin
                    st_d.cap_f = st_q.cap_f & ~pwdata[STAT_CAP_LSB +: NCH];
                    st_d.ovf_f = st_q.ovf_f & ~pwdata[STAT_OVF_BIT];
                end
                default: begin
                end
            endcase
        end

        // Flag sets come after clears so a same-cycle event wins
        if (tick && !clr_wr && st_q.cnt == CNT_MAX) begin
            st_d.ovf_f = 1'b1;
        end
        for (int i = 0; i < NCH; i++) begin
            if (hit[i]) begin
                st_d.cap[i]   = st_q.cnt;
                st_d.cap_f[i] = 1'b1;
            end
        end

        // Each request goes either to the CPU or to the transfer service
        st_d.ovf_irq  = st_d.ovf_f & st_d.ovf_ie & ~st_d.ovf_xs;
        st_d.ovf_xfer = st_d.ovf_f & st_d.ovf_ie & st_d.ovf_xs;
        st_d.cap_irq  = st_d.cap_f & st_d.cap_ie & ~st_d.cap_xs;
        st_d.cap_xfer = st_d.cap_f & st_d.cap_ie & st_d.cap_xs;

        // Answer prepared in setup so outputs come straight from flops;
        // read data is therefore the value one cycle before the access edge
        st_d.ready = psel & ~penable;
        st_d.err   = psel & ~penable & ~mapped_f(paddr);
        if (psel && !penable) begin
            st_d.rdata = mapped_f(paddr) ? rd_f(st_q, paddr) : WORD_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata       = st_q.rdata;
    assign pready       = st_q.ready;
    assign pslverr      = st_q.err;
    assign ovf_irq      = st_q.ovf_irq;
    assign ovf_xfer_req = st_q.ovf_xfer;
    assign cap_irq      = st_q.cap_irq;
    assign cap_xfer_req = st_q.cap_xfer;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_clr_write;
        clr_wr;
    endsequence

    sequence s_wrap;
        tick && !clr_wr && st_q.cnt == CNT_MAX;
    endsequence

    property p_clear;
        s_clr_write |=> st_q.cnt == CNT_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    property p_tick;
        tick && !clr_wr |=> st_q.cnt == $past(st_q.cnt) + 16'd1;
    endproperty
    a_tick: assert property (p_tick) else $error("counter missed tick");

    property p_no_tick;
        !tick && !clr_wr |=> $stable(st_q.cnt);
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("counter moved");

    property p_div2;
        (st_q.psc == 2'd1 && tick && !wr_en) ##1 !wr_en |-> !tick ##1 tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two broken");

    property p_wrap;
        s_wrap |=> st_q.ovf_f && st_q.cnt == CNT_RST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("overflow not flagged");

    property p_ovf_irq;
        s_wrap ##0 (st_q.ovf_ie && !st_q.ovf_xs && !wr_en) |=> ovf_irq && !ovf_xfer_req;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

    property p_ovf_xfer;
        st_q.ovf_f && st_q.ovf_ie && st_q.ovf_xs |-> ovf_xfer_req && !ovf_irq;
    endproperty
    a_ovf_xfer: assert property (p_ovf_xfer) else $error("overflow xfer missing");

    property p_cap_store;
        hit[0] |=> st_q.cap[0] == $past(st_q.cnt) && st_q.cap_f[0];
    endproperty
    a_cap_store: assert property (p_cap_store) else $error("capture not stored");

    property p_cap_hold;
        !hit[1] |=> $stable(st_q.cap[1]);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture value lost");

    property p_cap_irq;
        hit[0] && st_q.cap_ie[0] && !st_q.cap_xs[0] && !wr_en |=> cap_irq[0] && !cap_xfer_req[0];
    endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

    property p_cap_xfer;
        st_q.cap_f[3] && st_q.cap_ie[3] && st_q.cap_xs[3] |-> cap_xfer_req[3] && !cap_irq[3];
    endproperty
    a_cap_xfer: assert property (p_cap_xfer) else $error("capture xfer missing");

    ////////////////////////////////////////////////////////////////////////
    // Software clears that the sticky-flag checks must allow for
    logic ovf_w1c;
    logic cap3_w1c;
    assign ovf_w1c  = wr_en && (paddr == OFF_STAT) && pwdata[STAT_OVF_BIT];
    assign cap3_w1c = wr_en && (paddr == OFF_STAT) && pwdata[STAT_CAP_LSB + 3];

    property p_ovf_sticky;
        st_q.ovf_f && !ovf_w1c |=> st_q.ovf_f;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

    property p_ovf_source;
        !st_q.ovf_f && !(tick && st_q.cnt == CNT_MAX) |=> !st_q.ovf_f;
    endproperty
    a_ovf_source: assert property (p_ovf_source) else $error("overflow flag without wrap");

    property p_clear_no_ovf;
        s_clr_write ##0 !st_q.ovf_f |=> !st_q.ovf_f;
    endproperty
    a_clear_no_ovf: assert property (p_clear_no_ovf) else $error("clear raised overflow");

    property p_cap_sticky;
        st_q.cap_f[3] && !cap3_w1c |=> st_q.cap_f[3];
    endproperty
    a_cap_sticky: assert property (p_cap_sticky) else $error("capture flag lost");

    property p_cap_source;
        !st_q.cap_f[0] && !hit[0] |=> !st_q.cap_f[0];
    endproperty
    a_cap_source: assert property (p_cap_source) else $error("capture flag without edge");

    property p_edge_off;
        st_q.edge_sel[1:0] == EDGE_OFF |=> !hit[0];
    endproperty
    a_edge_off: assert property (p_edge_off) else $error("disabled channel hit");

    property p_shared_base;
        hit[0] && hit[3] |=> st_q.cap[0] == st_q.cap[3];
    endproperty
    a_shared_base: assert property (p_shared_base) else $error("time base not shared");

    property p_ovf_quiet;
        !st_q.ovf_ie |-> !ovf_irq && !ovf_xfer_req;
    endproperty
    a_ovf_quiet: assert property (p_ovf_quiet) else $error("overflow request while off");

    property p_cap_quiet;
        !st_q.cap_ie[1] |-> !cap_irq[1] && !cap_xfer_req[1];
    endproperty
    a_cap_quiet: assert property (p_cap_quiet) else $error("capture request while off");

    property p_cap_xfer2;
        hit[2] && st_q.cap_ie[2] && st_q.cap_xs[2] && !wr_en |=> cap_xfer_req[2] && !cap_irq[2];
    endproperty
    a_cap_xfer2: assert property (p_cap_xfer2) else $error("capture xfer late");

endmodule

`default_nettype wire

// file: rtl/frt_cap_pkg.sv
package frt_cap_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_CAPC  = 8'h08;
    localparam logic [7:0] OFF_STAT  = 8'h0C;
    localparam logic [7:0] OFF_CAP0  = 8'h10;
    localparam logic [7:0] OFF_CAP3  = 8'h1C;

    // Fields of timer_control_status_reg
    localparam int CTRL_PSC_LSB   = 0;
    localparam int CTRL_ZERO_BIT  = 2;
    localparam int CTRL_OVF_IE    = 3;
    localparam int CTRL_OVF_XS    = 4;

    // Fields of capture control register
    localparam int CAPC_EDGE_LSB  = 0;
    localparam int CAPC_IE_LSB    = 8;
    localparam int CAPC_XS_LSB    = 12;

    // Fields of status register (write one to clear)
    localparam int STAT_CAP_LSB   = 0;
    localparam int STAT_OVF_BIT   = 4;

    // Reset values
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;

    // Prescaler masks: divide by 1, 2, 4, 8; the fastest ratio keeps a full wrap short
    localparam logic [3:0] DIV_MASK0 = 4'h0;
    localparam logic [3:0] DIV_MASK1 = 4'h1;
    localparam logic [3:0] DIV_MASK2 = 4'h3;
    localparam logic [3:0] DIV_MASK3 = 4'h7;

    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    // Edge select codes
    localparam logic [1:0] EDGE_OFF  = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

endpackage

// file: rtl/cap_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none

module cap_edge_detect
    import frt_cap_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire logic [1:0] edge_sel,
    output logic            hit
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic hit;
    } det_t;

    det_t st_q;
    det_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // Pin is asynchronous: s1 feeds only s2; edges are judged on s2 vs s3
    always_comb begin
        st_d     = st_q;
        st_d.s1  = pin;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        case (edge_sel)
            EDGE_RISE: st_d.hit = st_q.s2 & ~st_q.s3;
            EDGE_FALL: st_d.hit = ~st_q.s2 & st_q.s3;
            EDGE_BOTH: st_d.hit = st_q.s2 ^ st_q.s3;
            default:   st_d.hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hit = st_q.hit;

endmodule

`default_nettype wire

// file: verification/cap_source_model.sv
`timescale 1ns/100ps
`default_nettype none

// Drives the capture pins like an outside device: levels change just after a rising edge
module cap_source_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] level_req,
    output logic      [3:0] pin
);
    // Registered so no edge ever lands on the sampling instant of the synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 4'h0;
        end else begin
            pin <= level_req;
        end
    end
endmodule

`default_nettype wire

// file: verification/free_run_timer_input_capture_tb.sv
`timescale 1ns/100ps
`default_nettype none

module free_run_timer_input_capture_tb
    import frt_cap_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  level_req = 4'h0;
    logic [3:0]  cap_pin;
    logic        ovf_irq;
    logic        ovf_xfer_req;
    logic [3:0]  cap_irq;
    logic [3:0]  cap_xfer_req;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cycles = 0;
    logic [15:0] prev [4];

    free_run_timer_input_capture #(.NCH(4)) i_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin), .ovf_irq(ovf_irq),
        .ovf_xfer_req(ovf_xfer_req), .cap_irq(cap_irq), .cap_xfer_req(cap_xfer_req));

    cap_source_model i_src (.clk(clk), .rst_n(rst_n), .level_req(level_req), .pin(cap_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a stuck handshake cannot hang the run;
    // one full counter wrap takes about 65536 cycles of the run
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // APB master: request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic err;
        apb(1'b0, a, 32'h0000_0000, d, err);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [31:0] v;
        for (int i = 0; i < 8; i++) begin
            if (i != 1) begin
                rd(8'(4 * i), v);
                check(v, WORD_RST);
            end
        end
        check({30'h0, ovf_irq, ovf_xfer_req}, 32'h0000_0000);
    endtask

    task automatic t_bus();
        logic [31:0] v;
        logic        err;
        wr(OFF_CTRL, 32'h0000_0018);
        rd(OFF_CTRL, v);
        check(v, 32'h0000_0018);
        wr(OFF_CAP0, 32'h0000_FFFF);
        rd(OFF_CAP0, v);
        check(v, WORD_RST);
        // Past the map and misaligned both answer with an error and zero data
        apb(1'b0, 8'h20, 32'h0000_0000, v, err);
        check({err, v[30:0]}, 32'h8000_0000);
        apb(1'b0, 8'h02, 32'h0000_0000, v, err);
        check({err, v[30:0]}, 32'h8000_0000);
        wr(OFF_CTRL, 32'h0000_0000);
    endtask

    // Ticks are periodic, so a fixed 64-cycle gap shows exactly 64/div counts
    task automatic t_prescale();
        logic [31:0] c0;
        logic [31:0] c1;
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CTRL, 32'(k) | 32'h0000_0004);
            rd(OFF_COUNT, c0);
            check({31'h0, c0 <= 32'd2}, 32'h0000_0001);
            repeat (61) @(posedge clk);
            rd(OFF_COUNT, c1);
            check(c1 - c0, 32'd64 >> k);
        end
        wr(OFF_CTRL, 32'h0000_0000);
    endtask

    task automatic edge_step(input logic [3:0] lvl, input logic hit);
        logic [31:0] c0;
        logic [31:0] c1;
        logic [31:0] v;
        logic [31:0] first;
        wr(OFF_STAT, 32'h0000_001F);
        rd(OFF_COUNT, c0);
        level_req <= lvl;
        repeat (8) @(posedge clk);
        rd(OFF_COUNT, c1);
        rd(OFF_STAT, v);
        check(v, hit ? 32'h0000_000F : 32'h0000_0000);
        check({cap_xfer_req, cap_irq}, hit ? 32'h0000_00C3 : 32'h0000_0000);
        for (int ch = 0; ch < 4; ch++) begin
            rd(8'(OFF_CAP0 + 4 * ch), v);
            if (ch == 0) begin
                first = v;
            end
            if (hit) begin
                check({31'h0, v >= c0 && v <= c1}, 32'h0000_0001);
                check(v, first);
            end else begin
                check(v, {16'h0, prev[ch]});
            end
            prev[ch] = v[15:0];
        end
    endtask

    // Every edge code, with channels 0-1 routed to interrupt and 2-3 to transfer
    task automatic t_capture();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wr(OFF_CAPC, {16'h0, 4'b1100, 4'hF, {4{m}}});
            wr(OFF_CTRL, 32'h0000_0004);
            edge_step(4'hF, m[0]);
            edge_step(4'h0, m[1]);
        end
    endtask

    // Full wrap at divide by one, CPU route, transfer route, then a mid-run reset
    task automatic t_overflow();
        logic [31:0] v;
        int          n;
        n = 0;
        wr(OFF_STAT, 32'h0000_000F);
        wr(OFF_CTRL, 32'h0000_000C);
        while (ovf_irq !== 1'b1 && n < 70000) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n >= 65536 && n <= 65537}, 32'h0000_0001);
        check({30'h0, ovf_xfer_req, ovf_irq}, 32'h0000_0001);
        rd(OFF_COUNT, v);
        check({31'h0, v <= 32'd16}, 32'h0000_0001);
        wr(OFF_CTRL, 32'h0000_0018);
        rd(OFF_STAT, v);
        check(v, 32'h0000_0010);
        check({30'h0, ovf_xfer_req, ovf_irq}, 32'h0000_0002);
        wr(OFF_STAT, 32'h0000_0010);
        rd(OFF_STAT, v);
        check(v, WORD_RST);
        check({30'h0, ovf_xfer_req, ovf_irq}, 32'h0000_0000);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_COUNT, v);
        check({31'h0, v <= 32'd2}, 32'h0000_0001);
        rd(OFF_CTRL, v);
        check(v, WORD_RST);
        check({22'h0, cap_xfer_req, cap_irq, ovf_xfer_req, ovf_irq}, WORD_RST);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        for (int ch = 0; ch < 4; ch++) begin
            prev[ch] = 16'h0000;
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_bus();
        t_prescale();
        t_capture();
        t_overflow();
        complete_run();
    end
endmodule

`default_nettype wire
